// ==== logic/mbxt_pkg.sv ====
// package for the extended data type access block: constants, types, carriers
package mbxt_pkg;

  // ----------------------------------------------------------------
  // register address layout
  // ----------------------------------------------------------------
  localparam int TYPE_HI_POS = 15;             // type_select_high
  localparam int TYPE_LO_POS = 14;             // type_select_low
  localparam int INDEX_W     = 14;             // parameter index, bits 0..13
  localparam int MENU_STRIDE = 100;            // index = menu * stride + item - 1

  // ----------------------------------------------------------------
  // data type selector
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MBXT_INT16 = 2'b00,                        // backward compatible
    MBXT_INT32 = 2'b01,
    MBXT_FLT32 = 2'b10,                        // single precision float
    MBXT_RSVD  = 2'b11
  } mbxt_type_t;

  // ----------------------------------------------------------------
  // function and exception codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_READ_MULTI   = 8'h03;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI  = 8'h10;
  localparam logic [7:0] FC_RW_MULTI     = 8'h17;
  localparam logic [7:0] FC_EXC_FLAG     = 8'h80;  // top bit marks an exception
  localparam logic [7:0] EXC_BAD_FUNC    = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR    = 8'h02;

  // ----------------------------------------------------------------
  // defaults of the core's limits
  // ----------------------------------------------------------------
  localparam int DEF_MAX_REGS    = 16;         // largest register count accepted
  localparam int DEF_PARAM_COUNT = 16384;      // parameters behind the index
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  func;                         // function code
    logic [15:0] start;                        // start register address
    logic [15:0] count;                        // number of 16-bit registers
  } mbxt_req_t;

  typedef struct packed {
    logic [31:0] value;                        // parameter value, low word if narrow
    logic        is_wide;                      // parameter is natively 32-bit
  } mbxt_param_t;

  typedef struct packed {
    logic [7:0] func;                          // function code with top bit set
    logic [7:0] code;                          // exception code
  } mbxt_exc_t;

  typedef struct packed {
    mbxt_type_t         dtype;                 // type for the whole block
    logic [INDEX_W-1:0] index;                 // first parameter index
    logic [15:0]        count;                 // parameters in the block
    logic [15:0]        byte_len;              // register data length in bytes
  } mbxt_dec_t;

endpackage

// ==== logic/mbxt_core.sv ====
// extended data type access: address decode, checks and width conversion
// Function
// - top two address bits select data type
// - low fourteen bits give parameter index
// - decode 00 int16, 01 int32, 10 float
// - float is single precision, may be unsupported
// - type applies to whole block
// - wide values as two words, high first
// - wide access only through multi-register codes
// - narrow read of wide parameter returns low word
// - wide read of narrow parameter sign-extends
// - odd count in wide access gives exception 2
// - exception reply carries function code with top bit
// - exception 2 for bad address or count
`timescale 1ns/1ps
module mbxt_core
  import mbxt_pkg::*;
#(
  parameter int MAX_REGS    = DEF_MAX_REGS,    // register count limit per request
  parameter int PARAM_COUNT = DEF_PARAM_COUNT, // number of addressable parameters
  parameter bit FLOAT_OK    = 1'b1             // float selection served
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire mbxt_req_t   req,
  output logic             dec_valid,
  output mbxt_dec_t        dec,
  output logic             exc_valid,
  input  wire logic        exc_ready,
  output mbxt_exc_t        exc,
  output logic             prm_req_valid,
  output logic [INDEX_W-1:0] prm_index,
  input  wire logic        prm_rsp_valid,
  input  wire mbxt_param_t prm_rsp,
  output logic             word_valid,
  input  wire logic        word_ready,
  output logic [15:0]      word,
  output logic             last_word,
  output logic             done
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (MAX_REGS < 2 || MAX_REGS > 65535) begin : g_bad_max
    $error("MAX_REGS must lie in 2..65535");
  end
  if (PARAM_COUNT < 1 || PARAM_COUNT > 16384) begin : g_bad_cnt
    $error("PARAM_COUNT must lie in 1..16384");
  end

  // ----------------------------------------------------------------
  // state machine encoding
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,                       // waiting for a request
    S_CHECK = 6'b000010,                       // decode and validate
    S_FETCH = 6'b000100,                       // ask for one parameter
    S_EMIT  = 6'b001000,                       // hand out words
    S_EXC   = 6'b010000,                       // exception reply pending
    S_DONE  = 6'b100000                        // block finished
  } mbxt_state_t;

  mbxt_state_t state_r;                        // current state
  mbxt_state_t state_nxt;                      // next state
  mbxt_req_t   req_r;                          // latched request
  logic [INDEX_W-1:0] idx_r;                   // parameter being served
  logic [15:0] left_r;                         // parameters still to send
  logic [15:0] lo_r;                           // held low word of a wide value
  logic        hi_phase_r;                     // word on output is the high half
  logic [15:0] word_r;                         // word on output
  logic        dec_valid_r;                    // one-cycle accept pulse
  mbxt_dec_t   dec_r;                          // decoded block
  mbxt_exc_t   exc_r;                          // exception reply fields

  // ----------------------------------------------------------------
  // decode of the latched request
  // ----------------------------------------------------------------
  wire mbxt_type_t sel_type = mbxt_type_t'(req_r.start[TYPE_HI_POS:TYPE_LO_POS]);
  wire [INDEX_W-1:0] sel_index = req_r.start[INDEX_W-1:0];
  wire sel_wide  = (sel_type == MBXT_INT32) || (sel_type == MBXT_FLT32);
  wire fc_single = (req_r.func == FC_WRITE_SINGLE);
  wire fc_multi  = (req_r.func == FC_READ_MULTI) || (req_r.func == FC_WRITE_MULTI)
                || (req_r.func == FC_RW_MULTI);
  wire fc_reads  = (req_r.func == FC_READ_MULTI) || (req_r.func == FC_RW_MULTI);
  wire fc_known  = fc_multi || fc_single;
  // a single write carries data, not a count, so it always moves one register
  wire [15:0] eff_count = fc_single ? 16'h0001 : req_r.count;
  wire [15:0] n_params  = sel_wide ? {1'b0, eff_count[15:1]} : eff_count;
  wire [16:0] idx_end   = 17'(sel_index) + 17'(n_params);
  wire bad_rsvd  = (sel_type == MBXT_RSVD);
  wire bad_float = (sel_type == MBXT_FLT32) && !FLOAT_OK;
  wire bad_fc32  = sel_wide && !fc_multi;
  wire bad_odd   = sel_wide && eff_count[0];
  wire bad_count = (eff_count == 16'h0000) || (32'(eff_count) > MAX_REGS);
  wire bad_range = (32'(idx_end) > PARAM_COUNT);
  wire bad_addr  = bad_rsvd || bad_float || bad_fc32 || bad_odd || bad_count
                || bad_range;
  wire chk_fail  = !fc_known || bad_addr;

  // ----------------------------------------------------------------
  // width conversion of a fetched parameter
  // ----------------------------------------------------------------
  wire [31:0] ext_val = prm_rsp.is_wide ? prm_rsp.value
                      : {{16{prm_rsp.value[15]}}, prm_rsp.value[15:0]};
  wire fetch_hit = (state_r == S_FETCH) && prm_rsp_valid;
  wire emit_hs   = (state_r == S_EMIT) && word_ready;
  wire last_prm  = (left_r == 16'h0001);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:  if (req_valid) state_nxt = S_CHECK;
      S_CHECK: begin
        if (chk_fail) begin
          state_nxt = S_EXC;
        end else if (fc_reads) begin
          state_nxt = S_FETCH;
        end else begin
          state_nxt = S_DONE;                  // writes leave data to the write path
        end
      end
      S_FETCH: if (prm_rsp_valid) state_nxt = S_EMIT;
      S_EMIT: begin
        if (word_ready && !hi_phase_r) begin
          state_nxt = last_prm ? S_DONE : S_FETCH;
        end
      end
      S_EXC:   if (exc_ready) state_nxt = S_IDLE;
      S_DONE:  state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) state_r <= S_IDLE;
    else       state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // request latch and block decode
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      req_r       <= '0;
      dec_r       <= '0;
      dec_valid_r <= 1'b0;
    end else begin
      if (state_r == S_IDLE && req_valid) req_r <= req;
      dec_valid_r <= (state_r == S_CHECK) && !chk_fail;
      if (state_r == S_CHECK) begin
        dec_r <= '{dtype: sel_type, index: sel_index, count: n_params,
                   byte_len: 16'(eff_count << 1)};
      end
    end
  end

  // ----------------------------------------------------------------
  // exception fields
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      exc_r <= '0;
    end else if (state_r == S_CHECK) begin
      exc_r.func <= req_r.func | FC_EXC_FLAG;
      exc_r.code <= fc_known ? EXC_BAD_ADDR : EXC_BAD_FUNC;
    end
  end

  // ----------------------------------------------------------------
  // block walk: index and remaining parameters
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idx_r  <= '0;
      left_r <= 16'h0000;
    end else if (state_r == S_CHECK) begin
      idx_r  <= sel_index;
      left_r <= n_params;
    end else if (emit_hs && !hi_phase_r) begin
      idx_r  <= idx_r + 1'b1;
      left_r <= left_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // output word; a wide value goes out high half first
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      word_r     <= RESET_WORD;
      lo_r       <= RESET_WORD;
      hi_phase_r <= 1'b0;
    end else if (fetch_hit) begin
      word_r     <= sel_wide ? ext_val[31:16] : prm_rsp.value[15:0];
      lo_r       <= ext_val[15:0];
      hi_phase_r <= sel_wide;
    end else if (emit_hs && hi_phase_r) begin
      word_r     <= lo_r;
      hi_phase_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready     = (state_r == S_IDLE);
  assign dec_valid     = dec_valid_r;
  assign dec           = dec_r;
  assign exc_valid     = (state_r == S_EXC);
  assign exc           = exc_r;
  assign prm_req_valid = (state_r == S_FETCH);
  assign prm_index     = idx_r;
  assign word_valid    = (state_r == S_EMIT);
  assign word          = word_r;
  assign last_word     = word_valid && last_prm && !hi_phase_r;
  assign done          = (state_r == S_DONE);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_type_index: assert property (@(posedge clock) disable iff (!rstn)
    (state_r == S_CHECK && !chk_fail) |=> dec_valid &&
      dec.index == $past(req_r.start[13:0]) && dec.dtype == $past(req_r.start[15:14]))
    else $error("decoded type or index wrong");

  a_rsvd_exc: assert property (@(posedge clock) disable iff (!rstn)
    (state_r == S_CHECK && fc_known && sel_type == MBXT_RSVD)
      |=> exc_valid && exc.code == 8'h02)
    else $error("reserved type not refused");

  a_odd_exc: assert property (@(posedge clock) disable iff (!rstn)
    (state_r == S_CHECK && fc_known && sel_wide && eff_count[0])
      |=> exc_valid && !word_valid && !prm_req_valid && !dec_valid)
    else $error("odd wide count not refused");

  a_float_off: assert property (@(posedge clock) disable iff (!rstn)
    (state_r == S_CHECK && sel_type == MBXT_FLT32 && !FLOAT_OK) |=> exc_valid)
    else $error("unsupported float accepted");

  a_exc_func: assert property (@(posedge clock) disable iff (!rstn)
    exc_valid |-> exc.func[7] && exc.func[6:0] == req_r.func[6:0])
    else $error("exception function code wrong");

  a_trunc_low: assert property (@(posedge clock) disable iff (!rstn)
    (fetch_hit && !sel_wide) |=> word_valid && word == $past(prm_rsp.value[15:0]))
    else $error("narrow access not truncated");

  a_sign_ext: assert property (@(posedge clock) disable iff (!rstn)
    (fetch_hit && sel_wide && !prm_rsp.is_wide)
      |=> word == {16{$past(prm_rsp.value[15])}})
    else $error("narrow value not sign extended");

  a_high_first: assert property (@(posedge clock) disable iff (!rstn)
    (fetch_hit && sel_wide && prm_rsp.is_wide) ##1 (word_valid && word_ready)
      |=> word_valid && word == $past(prm_rsp.value[15:0], 2) && !hi_phase_r)
    else $error("wide value word order wrong");

  a_count_lim: assert property (@(posedge clock) disable iff (!rstn)
    (state_r == S_CHECK && fc_known && 32'(eff_count) > MAX_REGS)
      |=> exc_valid ##0 exc.code == 8'h02)
    else $error("oversized count accepted");

endmodule

// ==== verification/mbxt_store.sv ====
// parameter store model that answers the core's fetch requests
`timescale 1ns/1ps
module mbxt_store
  import mbxt_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               prm_req_valid,
  input  wire logic [INDEX_W-1:0] prm_index,
  output logic                    prm_rsp_valid,
  output mbxt_param_t             prm_rsp
);
  // ----------------------------------------------------------------
  // contents and pacing
  // ----------------------------------------------------------------
  int wait_r;                                   // cycles spent on current fetch
  logic [1:0] delay;                            // odd index prompt, even index slow
  assign delay = prm_index[0] ? 2'd0 : 2'd3;

  // narrow values 128 and 129 carry junk above bit 15 so that a core that uses it is caught
  function automatic mbxt_param_t lookup(input logic [INDEX_W-1:0] idx);
    case (idx)
      14'd127: return '{32'h12345678, 1'b1};    // native wide parameter
      14'd128: return '{32'h5A5AABCD, 1'b0};    // negative narrow parameter
      14'd129: return '{32'hA5A50123, 1'b0};    // positive narrow parameter
      default: return '{{18'h0, idx}, 1'b0};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // answer one fetch after its delay, then release the data lines
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_r        <= 0;
      prm_rsp_valid <= 1'b0;
      prm_rsp       <= '0;
    end else if (prm_req_valid && !prm_rsp_valid && wait_r >= int'(delay)) begin
      prm_rsp_valid <= 1'b1;                    // value served by index
      prm_rsp       <= lookup(prm_index);
      wait_r        <= 0;
    end else begin
      prm_rsp_valid <= 1'b0;
      prm_rsp       <= ~prm_rsp;                // released lines keep changing
      wait_r        <= prm_req_valid && !prm_rsp_valid ? wait_r + 1 : 0;
    end
  end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the extended data type access core
`timescale 1ns/1ps
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD %s expected %h seen %h", what, exp, got); end end
module testbench;
  import mbxt_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               clock = 1'b0;
  logic               rstn = 1'b0;
  logic               req_valid = 1'b0, req_ready, dec_valid, exc_valid;
  logic               exc_ready = 1'b0, word_ready = 1'b1, word_valid, last_word, done;
  mbxt_req_t          req = '0;
  mbxt_dec_t          dec, got_dec;
  mbxt_exc_t          exc, got_exc;
  logic               prm_req_valid, prm_rsp_valid;
  logic [INDEX_W-1:0] prm_index;
  mbxt_param_t        prm_rsp;
  logic [15:0]        word;
  logic [15:0]        words[$];                 // words collected per request
  logic               saw_dec, saw_done, saw_exc, saw_last;
  int                 n_fail = 0, cmp_count = 0;
  logic               nf_exc_valid, nf_prm_req_valid, nf_word_valid; // core built without float
  mbxt_exc_t          nf_exc, got_nf;
  logic               saw_nf;                   // that core refused the current request

  always #10 clock = ~clock;                    // 50 MHz

  mbxt_core mbxt_core_inst (.clock(clock), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .dec_valid(dec_valid), .dec(dec),
    .exc_valid(exc_valid), .exc_ready(exc_ready), .exc(exc), .prm_req_valid(prm_req_valid),
    .prm_index(prm_index), .prm_rsp_valid(prm_rsp_valid), .prm_rsp(prm_rsp),
    .word_valid(word_valid), .word_ready(word_ready), .word(word), .last_word(last_word),
    .done(done));
  mbxt_store mbxt_store_inst (.clock(clock), .rstn(rstn), .prm_req_valid(prm_req_valid),
    .prm_index(prm_index), .prm_rsp_valid(prm_rsp_valid), .prm_rsp(prm_rsp));

  // a second core without float support serves itself at once, so it is always idle
  // again before the main core takes the next request
  if (1) begin : g_no_float
    mbxt_core #(.FLOAT_OK(1'b0)) mbxt_core_inst (.clock(clock), .rstn(rstn),
      .req_valid(req_valid), .req_ready(), .req(req), .dec_valid(), .dec(),
      .exc_valid(nf_exc_valid), .exc_ready(nf_exc_valid), .exc(nf_exc),
      .prm_req_valid(nf_prm_req_valid), .prm_index(), .prm_rsp_valid(nf_prm_req_valid),
      .prm_rsp(prm_rsp), .word_valid(nf_word_valid), .word_ready(nf_word_valid), .word(),
      .last_word(), .done());
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // offer one request, stall the word consumer now and then, collect the outcome
  task automatic run(input logic [7:0] f, input logic [15:0] s, input logic [15:0] c);
    int i;
    words.delete();
    saw_dec = 0; saw_done = 0; saw_exc = 0; saw_last = 0;
    saw_nf = 0;
    req = '{f, s, c};
    req_valid = 1'b1;
    i = 0;
    while (!req_ready && i < 50) begin @(negedge clock); i++; end
    if (!req_ready) begin n_fail++; finish_test(); end
    @(negedge clock);
    req_valid = 1'b0;
    for (i = 0; i < 200 && !saw_done && !(saw_exc && !exc_valid); i++) begin
      if (dec_valid) begin saw_dec = 1; got_dec = dec; end
      if (done) saw_done = 1;
      if (exc_valid) begin saw_exc = 1; got_exc = exc; end
      if (nf_exc_valid) begin saw_nf = 1; got_nf = nf_exc; end
      if (word_valid && word_ready) begin words.push_back(word); saw_last = last_word; end
      exc_ready = exc_valid;                    // take the exception after one look
      @(negedge clock);
      word_ready = (i % 3 != 1);
    end
    exc_ready = 1'b0;
    if (i >= 200) begin n_fail++; finish_test(); end
  endtask

  // the request must be refused with this function and code, and move no data
  task automatic chk_exc(input logic [7:0] f, input logic [7:0] code);
    `CHK("exception seen", 1'b1, saw_exc)
    `CHK("exception func", f | FC_EXC_FLAG, got_exc.func)
    `CHK("exception code", code, got_exc.code)
    `CHK("words moved", 0, words.size())
    `CHK("decode pulse", 1'b0, saw_dec)
  endtask

  task automatic chk_words(input logic [15:0] exp[]);
    `CHK("word count", exp.size(), words.size())
    foreach (exp[k]) if (k < words.size()) `CHK("word", exp[k], words[k])
    `CHK("last word flag", 1'b1, saw_last)
    `CHK("done pulse", 1'b1, saw_done)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_wide_mixed();              // index 127..129 as wide parameters
    run(FC_READ_MULTI, 16'h407F, 16'h0006);
    `CHK("dec type", MBXT_INT32, got_dec.dtype)
    `CHK("dec index", 14'd127, got_dec.index)
    `CHK("dec params", 16'h0003, got_dec.count)
    `CHK("dec bytes", 16'h000C, got_dec.byte_len)
    `CHK("int32 refused", 1'b0, saw_nf)
    chk_words('{16'h1234, 16'h5678, 16'hFFFF, 16'hABCD, 16'h0000, 16'h0123});
  endtask

  task automatic t_narrow();                  // same parameters through 16-bit access
    run(FC_READ_MULTI, 16'h007F, 16'h0003);
    `CHK("dec type", MBXT_INT16, got_dec.dtype)
    chk_words('{16'h5678, 16'hABCD, 16'h0123});
  endtask

  task automatic t_float();                   // float through the combined read code
    run(FC_RW_MULTI, 16'h807F, 16'h0002);
    `CHK("dec type", MBXT_FLT32, got_dec.dtype)
    `CHK("float refused", 1'b1, saw_nf)
    `CHK("float refusal code", EXC_BAD_ADDR, got_nf.code)
    chk_words('{16'h1234, 16'h5678});
  endtask

  task automatic t_write();                   // wide multi write only decodes
    run(FC_WRITE_MULTI, 16'h4080, 16'h0004);
    `CHK("dec seen", 1'b1, saw_dec)
    `CHK("dec params", 16'h0002, got_dec.count)
    `CHK("done pulse", 1'b1, saw_done)
    `CHK("words moved", 0, words.size())
  endtask

  task automatic t_refusals();                // each refusal except zero count and unsupported float, one after another
    run(FC_READ_MULTI, 16'h407F, 16'h0001);
    chk_exc(FC_READ_MULTI, EXC_BAD_ADDR);
    run(FC_READ_MULTI, 16'hC07F, 16'h0002);
    chk_exc(FC_READ_MULTI, EXC_BAD_ADDR);
    run(FC_WRITE_SINGLE, 16'h407F, 16'h0001);
    chk_exc(FC_WRITE_SINGLE, EXC_BAD_ADDR);
    run(8'h05, 16'h007F, 16'h0001);
    chk_exc(8'h05, EXC_BAD_FUNC);
    run(FC_READ_MULTI, 16'h0000, 16'h0011);
    chk_exc(FC_READ_MULTI, EXC_BAD_ADDR);
    run(FC_READ_MULTI, 16'h3FFF, 16'h0002);
    chk_exc(FC_READ_MULTI, EXC_BAD_ADDR);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    `CHK("ready after reset", 1'b1, req_ready)
    t_wide_mixed();
    t_narrow();
    t_float();
    t_refusals();
    t_write();
    t_wide_mixed();
    finish_test();
  end
endmodule
